// [logic/digital_watchdog_timer.v]
// Digital watchdog: reloadable 7-bit downcounter behind an AHB-Lite slave,
// with STOP/WAIT handling and MCU reset generation.
// Assumes a single AHB-Lite master, word transfers only, and CPU strobes
// (stop request, wake interrupt) on the same clock; the NMI pin is async.
`timescale 1ns/1ns
`include "watchdog_defines.vh"

// Operation
// - Counter running out while active resets MCU
// - Software option: inactive until activation bit written
// - Software cannot deactivate; only reset does
// - Inactive watchdog lets STOP halt the oscillator
// - Hardware option, no external control: STOP becomes WAIT
// - External control, NMI low: STOP becomes WAIT
// - External control, NMI high: freeze counter, STOP
// - Interrupt leaving STOP resumes counting from held value
// - Register resets to 0FEh, longest period
// - Writing software-reset bit zero resets immediately
// - Register count bits map reversed onto counter
// - Counter top bit falling triggers the reset
// - Sixty-four periods, 3072 to 196608 cycles
// - Hardware option: activation bit reads one, fixed
// - Inactive: plain 7-bit timer, no resets
// - Register at data address 0D8h, read/write
// - At least 28 instructions before first reset
// - Watchdog reset restarts like external, with delay
// - Reset pin driven low during watchdog reset
module digital_watchdog_timer #(
    parameter STAB_CYCLES = `WD_STAB_CYCLES
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    // CPU power control
    input  wire        stopReq,
    input  wire        wakeIrq,
    output wire        stopGrant,
    output wire        waitGrant,
    // Non-maskable interrupt pin level
    input  wire        nmiPin,
    // Reset outputs
    output wire        mcuReset,
    output wire        resetPinOut,
    output wire        resetPinOe
);

    // Register byte -> physical counter: byte bit 7 is counter bit 0
    function [6:0] regToCnt;
        input [7:0] r;
        begin
            regToCnt = {r[1], r[2], r[3], r[4], r[5], r[6], r[7]};
        end
    endfunction

    // Physical counter -> register byte, activation bit in bit 0
    function [7:0] cntToReg;
        input [6:0] c;
        input       act;
        begin
            cntToReg = {c[0], c[1], c[2], c[3], c[4], c[5], c[6], act};
        end
    endfunction

    // State
    reg  [6:0]         cnt_ff;
    reg                actEn_ff;
    reg  [1:0]         opt_ff;
    reg  [1:0]         mode_ff;
    reg                wdResetSeen_ff;
    reg  [11:0]        holdCnt_ff;
    reg                mcuReset_ff;
    reg                resetPinOe_ff;
    reg                resetPinOut_ff;
    reg                stopGrant_ff;
    reg                waitGrant_ff;
    reg  [31:0]        hrdata_ff;
    reg                hreadyout_ff;
    reg                hresp_ff;
    reg                wrPend_ff;
    reg  [7:0]         wrAddr_ff;
    reg                nmiMeta_ff;
    reg                nmiSync_ff;

    // Next values
    reg  [6:0]         nxt_cnt;
    reg                nxt_actEn;
    reg  [1:0]         nxt_mode;
    reg  [6:0]         decCnt;
    reg                fire;
    reg                reload;
    reg  [31:0]        rdValue;

    wire               hwAct    = opt_ff[`WD_OPT_HW_ACTIVATION];
    wire               extStop  = opt_ff[`WD_OPT_EXT_STOP];
    wire               active   = hwAct | actEn_ff;
    wire               frozen   = (mode_ff == `WD_MODE_STOP);
    wire               addrPh   = hsel & htrans[1] & hready;
    wire               wrCtrl   = wrPend_ff & (wrAddr_ff == `WD_ADDR_CTRL_COUNT);
    wire               wrOpt    = wrPend_ff & (wrAddr_ff == `WD_ADDR_OPTIONS);
    wire               wrSts    = wrPend_ff & (wrAddr_ff == `WD_ADDR_STATUS);
    wire               tick;

    assign hreadyout   = hreadyout_ff;
    assign hresp       = hresp_ff;
    assign hrdata      = hrdata_ff;
    assign stopGrant   = stopGrant_ff;
    assign waitGrant   = waitGrant_ff;
    assign mcuReset    = mcuReset_ff;
    assign resetPinOut = resetPinOut_ff;
    assign resetPinOe  = resetPinOe_ff;

    // Decrement enable; restarting on every reload gives a full first
    // period, so a counter run-out comes at least 3072 cycles after activation
    wdg_prescaler u_prescaler (
        .sys_clk (sys_clk),
        .rst     (rst),
        .run     (~frozen & ~mcuReset_ff),
        .restart (reload | (wrOpt & ~active & hwdata[`WD_OPT_HW_ACTIVATION])),
        .tick    (tick)
    );

    // NMI level crosses in from the pin
    always @(posedge sys_clk) begin
        if (rst) begin
            nmiMeta_ff <= 1'b0;
            nmiSync_ff <= 1'b0;
        end else begin
            nmiMeta_ff <= nmiPin;
            nmiSync_ff <= nmiMeta_ff;
        end
    end

    // Counter, activation and reset trigger
    always @* begin
        nxt_cnt   = cnt_ff;
        nxt_actEn = actEn_ff;
        fire      = 1'b0;
        reload    = 1'b0;
        decCnt    = cnt_ff - 7'h01;
        if (wrCtrl) begin
            reload  = 1'b1;
            nxt_cnt = regToCnt(hwdata[7:0]);
            if (hwdata[`WD_BIT_ACTIVE]) begin
                nxt_actEn = 1'b1;
            end
            // Clearing the software-reset bit fires once the watchdog is on
            if ((active | hwdata[`WD_BIT_ACTIVE]) && !hwdata[`WD_BIT_SOFT_RESET]) begin
                fire = 1'b1;
            end
        end else if (tick && !frozen) begin
            nxt_cnt = decCnt;
            // Only the top bit falling counts, so the low six set the period
            if (active && cnt_ff[`WD_CNT_TOP_BIT] && !decCnt[`WD_CNT_TOP_BIT]) begin
                fire = 1'b1;
            end
        end
    end

    // Power mode: STOP only halts the count when the watchdog allows it
    always @* begin
        nxt_mode = mode_ff;
        case (mode_ff)
            `WD_MODE_RUN: begin
                if (stopReq) begin
                    if (!active) begin
                        nxt_mode = `WD_MODE_STOP;
                    end else if (extStop && nmiSync_ff) begin
                        nxt_mode = `WD_MODE_STOP;
                    end else begin
                        nxt_mode = `WD_MODE_WAIT;
                    end
                end
            end
            `WD_MODE_WAIT: begin
                if (wakeIrq) begin
                    nxt_mode = `WD_MODE_RUN;
                end
            end
            `WD_MODE_STOP: begin
                if (wakeIrq) begin
                    nxt_mode = `WD_MODE_RUN;
                end
            end
            default: begin
                nxt_mode = `WD_MODE_RUN;
            end
        endcase
    end

    // Read mux, sampled in the address phase
    always @* begin
        rdValue = 32'h0000_0000;
        case (haddr[7:0])
            `WD_ADDR_CTRL_COUNT: rdValue = {24'h000000, cntToReg(cnt_ff, active)};
            `WD_ADDR_OPTIONS:    rdValue = {30'h0000000, opt_ff};
            `WD_ADDR_STATUS:     rdValue = {28'h0000000, wdResetSeen_ff,
                                            mode_ff == `WD_MODE_WAIT, frozen, active};
            default:             rdValue = 32'h0000_0000;
        endcase
    end

    // Bus slave: zero wait states, always OKAY, writes land in the data phase
    always @(posedge sys_clk) begin
        if (rst) begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
            hrdata_ff    <= 32'h0000_0000;
            wrPend_ff    <= 1'b0;
            wrAddr_ff    <= 8'h00;
        end else begin
            wrPend_ff <= addrPh & hwrite & (haddr[31:8] == 24'h000000);
            wrAddr_ff <= haddr[7:0];
            if (addrPh && !hwrite && haddr[31:8] == 24'h000000) begin
                hrdata_ff <= rdValue;
            end else if (addrPh) begin
                hrdata_ff <= 32'h0000_0000;   // Unmapped reads see zero
            end
        end
    end

    // Watchdog state, reset hold and options
    always @(posedge sys_clk) begin
        if (rst) begin
            cnt_ff         <= regToCnt(`WD_CTRL_RESET);
            actEn_ff       <= 1'b0;
            opt_ff         <= `WD_OPT_RESET;
            mode_ff        <= `WD_MODE_RUN;
            wdResetSeen_ff <= 1'b0;
            holdCnt_ff     <= 12'h000;
            mcuReset_ff    <= 1'b0;
            resetPinOe_ff  <= 1'b0;
            resetPinOut_ff <= 1'b0;
            stopGrant_ff   <= 1'b0;
            waitGrant_ff   <= 1'b0;
        end else if (mcuReset_ff) begin
            // Hold the MCU for the stabilisation delay, counter, activation and power mode at reset values, options kept
            cnt_ff        <= regToCnt(`WD_CTRL_RESET);
            actEn_ff      <= 1'b0;
            mode_ff       <= `WD_MODE_RUN;
            stopGrant_ff  <= 1'b0;
            waitGrant_ff  <= 1'b0;
            if (holdCnt_ff == 12'h000) begin
                mcuReset_ff   <= 1'b0;
                resetPinOe_ff <= 1'b0;
            end else begin
                holdCnt_ff <= holdCnt_ff - 12'h001;
            end
        end else begin
            cnt_ff       <= nxt_cnt;
            actEn_ff     <= nxt_actEn;
            mode_ff      <= nxt_mode;
            stopGrant_ff <= (nxt_mode == `WD_MODE_STOP);
            waitGrant_ff <= (nxt_mode == `WD_MODE_WAIT);
            // Options lock once active, so a write cannot switch the watchdog off
            if (wrOpt && !active) begin
                opt_ff <= hwdata[1:0];
            end
            if (fire) begin
                mcuReset_ff   <= 1'b1;
                resetPinOe_ff <= 1'b1;
                holdCnt_ff    <= STAB_CYCLES[11:0] - 12'h001;
            end
            // Sticky cause flag: a new watchdog reset wins over the clear
            if (fire) begin
                wdResetSeen_ff <= 1'b1;
            end else if (wrSts && hwdata[`WD_STS_WD_RESET]) begin
                wdResetSeen_ff <= 1'b0;
            end
        end
    end

endmodule // digital_watchdog_timer

// [pkg/watchdog_defines.vh]
// Constants for the digital watchdog: register map, field positions,
// reset values and timing counts.
// Assumes the includer runs on a 125 MHz system clock.
`ifndef WATCHDOG_DEFINES_VH
`define WATCHDOG_DEFINES_VH

// Byte addresses of the word-aligned registers
`define WD_ADDR_CTRL_COUNT   8'hD8
`define WD_ADDR_OPTIONS      8'hDC
`define WD_ADDR_STATUS       8'hE0

// Control/count register layout
`define WD_BIT_ACTIVE        0
`define WD_BIT_SOFT_RESET    1
`define WD_CTRL_RESET        8'hFE

// Option register layout
`define WD_OPT_HW_ACTIVATION 0
`define WD_OPT_EXT_STOP      1
`define WD_OPT_RESET         2'h0

// Status register layout
`define WD_STS_ACTIVE        0
`define WD_STS_FROZEN        1
`define WD_STS_WAITING       2
`define WD_STS_WD_RESET      3

// Downcounter geometry
`define WD_CNT_WIDTH         7
`define WD_CNT_TOP_BIT       6

// Timing in system clock cycles
`define WD_TICK_CYCLES       12'hC00
`define WD_PERIOD_MIN_CYC    3072
`define WD_PERIOD_MAX_CYC    196608
`define WD_STAB_CYCLES       2048

// Power mode state codes
`define WD_MODE_RUN          2'h0
`define WD_MODE_WAIT         2'h1
`define WD_MODE_STOP         2'h2

`endif

// [logic/wdg_prescaler.v]
// Prescaler that turns the system clock into the watchdog decrement enable.
// Assumes run and restart come from logic on the same clock.
`timescale 1ns/1ns
`include "watchdog_defines.vh"

module wdg_prescaler (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // Control
    input  wire        run,
    input  wire        restart,
    // One-cycle decrement enable
    output wire        tick
);

    reg  [11:0]        div_ff;

    // Pulse in the last cycle of a period; left unregistered so that a reload
    // sees exactly one full period, not one extra cycle, before its first step
    assign tick = run & (div_ff == `WD_TICK_CYCLES - 12'h001);

    // Divide by the tick period; restart begins a fresh period after any reload
    always @(posedge sys_clk) begin
        if (rst || restart) begin
            div_ff <= 12'h000;
        end else if (run) begin
            if (tick) begin
                div_ff <= 12'h000;
            end else begin
                div_ff <= div_ff + 12'h001;
            end
        end
    end

endmodule // wdg_prescaler

// [sim/wdt_checker_properties.sv]
// Port-level checks for the digital watchdog.
// Assumes it is bound into digital_watchdog_timer on its one clock.
`timescale 1ns/1ns
module wdt_checker #(
    parameter STAB_CYCLES = 8
) (
    // Clock and reset
    input wire        sys_clk,
    input wire        rst,
    // Register bus
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    // Power control and resets
    input wire        stopReq,
    input wire        wakeIrq,
    input wire        stopGrant,
    input wire        waitGrant,
    input wire        mcuReset,
    input wire        resetPinOut,
    input wire        resetPinOe
);
    reg  [12:0] hiCnt_ff;
    wire        rdOther = hsel && htrans[1] && hready && !hwrite && haddr != 32'hD8 && haddr != 32'hDC
                          && haddr != 32'hE0;

    // Length of the running reset pulse; a counter keeps long pulses cheap to check
    always @(posedge sys_clk) begin
        if (rst || !mcuReset) hiCnt_ff <= 13'h0;
        else hiCnt_ff <= hiCnt_ff + 13'h1;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    bus_okay_a:
        assert property (hresp == 1'b0 && hreadyout == 1'b1) else $error("bus answer not ready or not okay");
    upper_zero_a:
        assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits not zero");
    unmapped_zero_a:
        assert property (rdOther |=> hrdata == 32'h0) else $error("unmapped read not zero");
    pin_follow_a:
        assert property (resetPinOe == mcuReset && resetPinOut == 1'b0) else $error("reset pin not following");
    pulse_end_a:
        assert property ($fell(mcuReset) |-> hiCnt_ff == STAB_CYCLES) else $error("reset pulse length wrong");
    pulse_max_a:
        assert property (mcuReset |-> hiCnt_ff < STAB_CYCLES) else $error("reset pulse too long");
    grant_excl_a:
        assert property (!(stopGrant && waitGrant)) else $error("stop and wait granted together");
    stop_enter_a:
        assert property (stopReq && !wakeIrq && !mcuReset && !stopGrant && !waitGrant |=> stopGrant != waitGrant)
        else $error("stop request not answered");
    wake_exit_a:
        assert property (wakeIrq && !stopReq && !mcuReset && (stopGrant || waitGrant) |=> !stopGrant && !waitGrant)
        else $error("wake did not return to run");
    reset_idle_a:
        assert property ($fell(rst) |-> !mcuReset && !stopGrant && !waitGrant && hrdata == 32'h0)
        else $error("outputs not idle after reset");
endmodule // wdt_checker

bind digital_watchdog_timer wdt_checker #(.STAB_CYCLES(STAB_CYCLES)) u_props (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stopReq(stopReq),
    .wakeIrq(wakeIrq), .stopGrant(stopGrant), .waitGrant(waitGrant), .mcuReset(mcuReset),
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe));

// [sim/tb_top.sv]
// Self-checking bench for the digital watchdog: registers, timing,
// power modes and reset generation.
// Assumes the design and its bound checker are compiled alongside.
`timescale 1ns/1ns
`include "watchdog_defines.vh"
module tb_top;
    localparam STAB = 8;
    localparam TICK = 3072;
    reg         sys_clk = 1'b0;
    reg         rst = 1'b1;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0;
    reg         stopReq = 1'b0;
    reg         wakeIrq = 1'b0;
    reg         nmiPin = 1'b0;
    wire        hreadyout, hresp, stopGrant, waitGrant, mcuReset, resetPinOut, resetPinOe;
    wire [31:0] hrdata;
    integer     failures = 0;
    integer     cmp_count = 0;
    integer     i, k;
    reg  [31:0] n, rd;
    reg  [6:0]  c;

    digital_watchdog_timer #(.STAB_CYCLES(STAB)) dut (
        .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .stopReq(stopReq), .wakeIrq(wakeIrq), .stopGrant(stopGrant), .waitGrant(waitGrant),
        .nmiPin(nmiPin), .mcuReset(mcuReset), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe));

    always #4 sys_clk = ~sys_clk;

    // Register image of a counter value; count bits sit reversed
    function [7:0] img(input [6:0] cv, input act);
        img = {cv[0], cv[1], cv[2], cv[3], cv[4], cv[5], cv[6], act};
    endfunction

    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("unexpected %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask

    // One single AHB-Lite word transfer; waits for ready in both phases
    task bus(input wr, input [7:0] a, input [7:0] wd);
        begin
            hsel <= 1'b1;
            haddr <= {24'h0, a};
            htrans <= 2'h2;
            hwrite <= wr;
            @(posedge sys_clk);
            while (hreadyout !== 1'b1) @(posedge sys_clk);
            htrans <= 2'h0;
            hsel <= 1'b0;
            hwdata <= {24'h0, wd};
            @(posedge sys_clk);
            while (hreadyout !== 1'b1) @(posedge sys_clk);
            rd = hrdata;
        end
    endtask

    task rdchk(input [7:0] a, input [7:0] exp, input string nm);
        begin
            bus(1'b0, a, 8'h00);
            chk(nm, {24'h0, exp}, rd);
        end
    endtask

    // Settled sample point a little after the edge
    task idle(input integer cyc);
        begin
            repeat (cyc) @(posedge sys_clk);
            #1;
        end
    endtask

    // Stop or wake strobe, then the granted mode
    task pwr(input wake, input expStop, input expWait);
        begin
            if (wake) wakeIrq <= 1'b1;
            else stopReq <= 1'b1;
            @(posedge sys_clk);
            wakeIrq <= 1'b0;
            stopReq <= 1'b0;
            #1;
            chk("stopGrant", expStop, stopGrant);
            chk("waitGrant", expWait, waitGrant);
        end
    endtask

    task doReset;
        begin
            rst <= 1'b1;
            repeat (6) @(posedge sys_clk);
            rst <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    task test_done;
        begin
            if (failures == 0 && cmp_count > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask

    initial begin
        n = $urandom(32'hC72C);
        doReset;
        // Reset image, map and unmapped space
        rdchk(`WD_ADDR_CTRL_COUNT, 8'hFE, "ctrl");
        rdchk(`WD_ADDR_OPTIONS, 8'h00, "options");
        bus(1'b1, 8'hC0, 8'h5A);
        rdchk(8'hC0, 8'h00, "unmapped");
        // Timer mode: reversed bits, one step per tick, free wrap from zero
        for (i = 0; i < 5; i = i + 1) begin
            n = $urandom;
            c = (i == 0) ? 7'h00 : n[6:0];
            bus(1'b1, `WD_ADDR_CTRL_COUNT, img(c, 1'b0));
            rdchk(`WD_ADDR_CTRL_COUNT, img(c, 1'b0), "ctrl");
            idle(TICK);
            rdchk(`WD_ADDR_CTRL_COUNT, img(c - 7'h1, 1'b0), "ctrl");
            chk("mcuReset", 1'b0, mcuReset);
        end
        // Activation sticks and locks the options
        bus(1'b1, `WD_ADDR_CTRL_COUNT, 8'hFF);
        bus(1'b1, `WD_ADDR_CTRL_COUNT, 8'hFE);
        rdchk(`WD_ADDR_CTRL_COUNT, 8'hFF, "ctrl");
        bus(1'b1, `WD_ADDR_OPTIONS, 8'h03);
        rdchk(`WD_ADDR_OPTIONS, 8'h00, "options");
        // Clearing the software-reset bit fires at once
        bus(1'b1, `WD_ADDR_CTRL_COUNT, 8'hFD);
        idle(0);
        chk("mcuReset", 1'b1, mcuReset);
        chk("resetPinOe", 1'b1, resetPinOe);
        k = 0;
        while (mcuReset === 1'b1 && k < 100) begin
            idle(1);
            k = k + 1;
        end
        chk("pulse", STAB, k);
        rdchk(`WD_ADDR_CTRL_COUNT, 8'hFE, "ctrl");
        rdchk(`WD_ADDR_STATUS, 8'h08, "status");
        bus(1'b1, `WD_ADDR_STATUS, 8'h08);
        rdchk(`WD_ADDR_STATUS, 8'h00, "status");
        // Active counter runs down after k+1 steps
        n = $urandom;
        k = n[1:0];
        bus(1'b1, `WD_ADDR_CTRL_COUNT, img(7'h40 + n[1:0], 1'b1));
        idle(TICK * (k + 1) - 2);
        chk("mcuReset", 1'b0, mcuReset);
        idle(4);
        chk("mcuReset", 1'b1, mcuReset);
        idle(STAB);
        // Inactive watchdog allows a true stop
        doReset;
        pwr(1'b0, 1'b1, 1'b0);
        pwr(1'b1, 1'b0, 1'b0);
        // Hardware activation: fixed bit, stop becomes wait, counting goes on
        bus(1'b1, `WD_ADDR_OPTIONS, 8'h01);
        bus(1'b1, `WD_ADDR_CTRL_COUNT, 8'hFE);
        rdchk(`WD_ADDR_CTRL_COUNT, 8'hFF, "ctrl");
        pwr(1'b0, 1'b0, 1'b1);
        rdchk(`WD_ADDR_STATUS, 8'h05, "status");
        idle(TICK);
        rdchk(`WD_ADDR_CTRL_COUNT, img(7'h7E, 1'b1), "ctrl");
        pwr(1'b1, 1'b0, 1'b0);
        // External stop control chosen by the interrupt pin level
        doReset;
        bus(1'b1, `WD_ADDR_OPTIONS, 8'h03);
        pwr(1'b0, 1'b0, 1'b1);
        pwr(1'b1, 1'b0, 1'b0);
        nmiPin <= 1'b1;
        idle(3);
        bus(1'b1, `WD_ADDR_CTRL_COUNT, 8'hFF);
        pwr(1'b0, 1'b1, 1'b0);
        idle(TICK + 1000);
        rdchk(`WD_ADDR_CTRL_COUNT, 8'hFF, "ctrl");
        rdchk(`WD_ADDR_STATUS, 8'h03, "status");
        pwr(1'b1, 1'b0, 1'b0);
        idle(TICK);
        rdchk(`WD_ADDR_CTRL_COUNT, img(7'h7E, 1'b1), "ctrl");
        test_done;
    end

    // Hang guard well beyond the expected run length of about 40000 cycles
    initial begin
        repeat (60000) @(posedge sys_clk);
        failures = failures + 1;
        test_done;
    end
endmodule // tb_top
